/* File: rtl/bmrh_pkg.sv */
/*
  Shared constants for the buffered modem RTS handshake relay: clock
  rate, bit-rate dividers, switch field positions, wait and hold times.
  Assumes a 40 MHz system clock and 16x oversampled serial links.
*/
package bmrh_pkg;

  ////////////////////////////////////////////////////////////////////////
  // clock and oversampling
  localparam int CLK_HZ = 40_000_000;
  localparam int CLK_PERIOD_PS = 25_000;
  localparam int OVS = 16;
  localparam logic [3:0] OVS_LAST = 4'hf;
  localparam logic [3:0] OVS_MID = 4'h7;

  ////////////////////////////////////////////////////////////////////////
  // bit rates and their 16x divisors (reload value = count - 1)
  localparam int DIV_W = 12;
  localparam logic [DIV_W-1:0] DIV_1200 = DIV_W'(CLK_HZ / (1200 * OVS) - 1);
  localparam logic [DIV_W-1:0] DIV_2400 = DIV_W'(CLK_HZ / (2400 * OVS) - 1);
  localparam logic [DIV_W-1:0] DIV_4800 = DIV_W'(CLK_HZ / (4800 * OVS) - 1);
  localparam logic [DIV_W-1:0] DIV_9600 = DIV_W'(CLK_HZ / (9600 * OVS) - 1);
  localparam logic [DIV_W-1:0] DIV_19200 = DIV_W'(CLK_HZ / (19200 * OVS) - 1);
  localparam logic [2:0] RATE_1200 = 3'h0;
  localparam logic [2:0] RATE_2400 = 3'h1;
  localparam logic [2:0] RATE_4800 = 3'h2;
  localparam logic [2:0] RATE_9600 = 3'h3;
  localparam logic [2:0] RATE_19200 = 3'h4;

  ////////////////////////////////////////////////////////////////////////
  // config switch bank fields
  localparam int SW_RATE_LSB = 0;
  localparam int SW_SEVEN = 3;
  localparam int SW_PAR_EN = 4;
  localparam int SW_PAR_ODD = 5;
  localparam int SW_WAIT_LSB = 6;
  localparam logic [1:0] WAIT_CTS = 2'h0;
  localparam logic [1:0] WAIT_5MS = 2'h1;
  localparam logic [1:0] WAIT_10MS = 2'h2;
  localparam logic [1:0] WAIT_50MS = 2'h3;

  ////////////////////////////////////////////////////////////////////////
  // times
  localparam int MS_NS = 1_000_000;
  localparam logic [5:0] WAIT_5_MS = 6'h05;
  localparam logic [5:0] WAIT_10_MS = 6'h0a;
  localparam logic [5:0] WAIT_50_MS = 6'h32;
  localparam int HANG_CHARS = 2;
  localparam int DRV_HOLD_BITS = 10;

  ////////////////////////////////////////////////////////////////////////
  // buffer and frame
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 160;
  localparam logic [3:0] FRAME_EXTRA = 4'h2;

  typedef enum logic [1:0] {
    BMRH_IDLE,
    BMRH_WAIT,
    BMRH_SEND,
    BMRH_HOLD
  } bmrh_mstate_e;

endpackage

/* File: rtl/bmrh_fifo.sv */
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes one clock; the writer honours in_ready_o, the reader may stall.
*/
`timescale 1ns/1ps
module bmrh_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [W-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [W-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [CW-1:0] cnt_q;

  // flow control
  wire push = in_valid_i & in_ready_o;
  wire pop = out_valid_o & out_ready_i;
  assign in_ready_o = cnt_q != CNT_FULL;
  assign out_valid_o = cnt_q != '0;
  assign out_data_o = mem_q[rd_q];

  // storage
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  // pointers and fill count
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == PTR_LAST) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == PTR_LAST) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + CW'(push) - CW'(pop);
    end
  end
endmodule

/* File: rtl/bmrh_ser.sv */
/*
  One asynchronous serial link: receiver and transmitter, 16x oversampled.
  Assumes rxd_i already synchronised and a shared tick_i at 16x bit rate.
*/
`timescale 1ns/1ps
module bmrh_ser (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic tick_i,
  input wire logic seven_i,
  input wire logic par_en_i,
  input wire logic par_odd_i,
  input wire logic rxd_i,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  output logic rx_perr_o,
  output logic rx_busy_o,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  output logic tx_busy_o,
  output logic txd_o
);
  logic rx_act_q, rx_valid_q, rx_perr_q;
  logic [3:0] rx_tick_q, rx_idx_q;
  logic [8:0] rx_sh_q;
  logic [7:0] rx_data_q;
  logic [10:0] tx_sh_q;
  logic [3:0] tx_left_q, tx_tick_q;
  logic txd_q;

  // frame geometry
  wire [3:0] n_data = seven_i ? 4'h7 : 4'h8;
  wire [3:0] n_pay = n_data + {3'h0, par_en_i};
  wire [3:0] n_frame = n_pay + bmrh_pkg::FRAME_EXTRA;

  // receive decode, payload right aligned, lsb first
  wire rx_sample = tick_i & (rx_tick_q == bmrh_pkg::OVS_LAST);
  wire rx_at_stop = rx_idx_q == (n_pay + 4'h1);
  wire [8:0] rx_al = rx_sh_q >> (4'h9 - n_pay);
  wire [7:0] rx_dat = seven_i ? {1'b0, rx_al[6:0]} : rx_al[7:0];
  wire rx_par_bad = par_en_i & ((^rx_dat) ^ rx_al[n_data] ^ par_odd_i);

  // receiver: start, payload, stop sampled mid bit
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_act_q <= 1'b0;
      rx_tick_q <= '0;
      rx_idx_q <= '0;
      rx_sh_q <= '0;
      rx_data_q <= '0;
      rx_valid_q <= 1'b0;
      rx_perr_q <= 1'b0;
    end else begin
      rx_valid_q <= 1'b0;
      rx_perr_q <= 1'b0;
      if (!rx_act_q) begin
        if (!rxd_i) begin
          rx_act_q <= 1'b1;
          rx_tick_q <= bmrh_pkg::OVS_MID;
          rx_idx_q <= '0;
        end
      end else if (tick_i) begin
        rx_tick_q <= rx_tick_q + 4'h1;
        if (rx_sample) begin
          if (rx_idx_q == '0 && rxd_i) begin
            rx_act_q <= 1'b0; // glitch, not a start
          end else if (rx_at_stop) begin
            rx_act_q <= 1'b0;
            rx_valid_q <= rxd_i;
            rx_perr_q <= rxd_i & rx_par_bad;
            rx_data_q <= rx_dat;
          end else begin
            rx_sh_q <= {rxd_i, rx_sh_q[8:1]};
            rx_idx_q <= rx_idx_q + 4'h1;
          end
        end
      end
    end
  end

  assign rx_data_o = rx_data_q;
  assign rx_valid_o = rx_valid_q;
  assign rx_perr_o = rx_perr_q;
  assign rx_busy_o = rx_act_q;

  // transmit frame: start, data lsb first, parity, stop
  wire tx_par = (seven_i ? ^tx_data_i[6:0] : ^tx_data_i) ^ par_odd_i;
  wire [10:0] tx_frame = seven_i ? {2'h3, tx_par, tx_data_i[6:0], 1'b0} :
                         {1'b1, par_en_i ? tx_par : 1'b1, tx_data_i, 1'b0};
  assign tx_busy_o = tx_left_q != '0;
  assign tx_ready_o = !tx_busy_o;

  // transmitter shift
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_sh_q <= '1;
      tx_left_q <= '0;
      tx_tick_q <= '0;
      txd_q <= 1'b1;
    end else if (tx_valid_i && !tx_busy_o) begin
      tx_sh_q <= tx_frame;
      tx_left_q <= n_frame;
      tx_tick_q <= '0;
      txd_q <= 1'b0;
    end else if (tx_busy_o && tick_i) begin
      tx_tick_q <= tx_tick_q + 4'h1;
      if (tx_tick_q == bmrh_pkg::OVS_LAST) begin
        tx_sh_q <= {1'b1, tx_sh_q[10:1]};
        tx_left_q <= tx_left_q - 4'h1;
        txd_q <= (tx_left_q == 4'h1) ? 1'b1 : tx_sh_q[1];
      end
    end
  end

  assign txd_o = txd_q;
endmodule

/* File: rtl/bmrh_top.sv */
/*
  Buffered relay between a host serial port and an RS-232 radio modem:
  buffers host characters while raising RTS and waiting, then forwards
  them; relays modem data back to the host and steers the host-side
  differential driver and receiver. Assumes one 40 MHz clock, all pins
  asynchronous to it, and configuration straps stable at power-up.
*/
`timescale 1ns/1ps
module bmrh_top #(
  parameter int MS_CYCLES = bmrh_pkg::MS_NS * 1000 / bmrh_pkg::CLK_PERIOD_PS
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] config_switch_bank_i,
  input wire logic duplex_select_jumper_i,
  input wire logic host_rxd_i,
  output logic host_txd_o,
  output logic host_cts_o,
  output logic host_drv_en_o,
  output logic host_rcv_dis_o,
  output logic modem_txd_o,
  input wire logic modem_rxd_i,
  output logic modem_rts_o,
  input wire logic modem_cts_i,
  output logic parity_err_o
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  localparam logic [11:0] SYNC_RST = 12'h006; // serial lines idle high
  logic [11:0] sync_a_q, sync_b_q;

  // two flops on every asynchronous input
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync_a_q <= SYNC_RST;
      sync_b_q <= SYNC_RST;
    end else begin
      sync_a_q <= {config_switch_bank_i, duplex_select_jumper_i,
                   host_rxd_i, modem_rxd_i, modem_cts_i};
      sync_b_q <= sync_a_q;
    end
  end

  wire [7:0] sw_s = sync_b_q[11:4];
  wire jumper_s = sync_b_q[3];
  wire host_rxd_s = sync_b_q[2];
  wire modem_rxd_s = sync_b_q[1];
  wire modem_cts_s = sync_b_q[0];

  ////////////////////////////////////////////////////////////////////////
  // power-up configuration capture
  logic [1:0] cfg_wait_cnt_q;
  logic cfg_done_q;
  logic [2:0] cfg_rate_q;
  logic cfg_seven_q, cfg_par_en_q, cfg_par_odd_q, cfg_half_q;
  logic [1:0] cfg_wait_q;

  // one capture after the synchronisers settle, never again
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_wait_cnt_q <= '0;
      cfg_done_q <= 1'b0;
      cfg_rate_q <= bmrh_pkg::RATE_9600;
      cfg_seven_q <= 1'b0;
      cfg_par_en_q <= 1'b0;
      cfg_par_odd_q <= 1'b0;
      cfg_half_q <= 1'b0;
      cfg_wait_q <= bmrh_pkg::WAIT_CTS;
    end else if (!cfg_done_q) begin
      cfg_wait_cnt_q <= cfg_wait_cnt_q + 2'h1;
      if (cfg_wait_cnt_q == 2'h3) begin
        cfg_done_q <= 1'b1;
        cfg_rate_q <= sw_s[bmrh_pkg::SW_RATE_LSB +: 3];
        cfg_seven_q <= sw_s[bmrh_pkg::SW_SEVEN];
        cfg_par_en_q <= sw_s[bmrh_pkg::SW_PAR_EN];
        cfg_par_odd_q <= sw_s[bmrh_pkg::SW_PAR_ODD];
        cfg_wait_q <= sw_s[bmrh_pkg::SW_WAIT_LSB +: 2];
        cfg_half_q <= jumper_s;
      end
    end
  end

  // seven bits without parity runs as eight bits without parity
  wire seven_eff = cfg_seven_q & cfg_par_en_q;

  ////////////////////////////////////////////////////////////////////////
  // 16x bit-rate tick
  logic [bmrh_pkg::DIV_W-1:0] div_q;
  logic [bmrh_pkg::DIV_W-1:0] div_reload;

  // rate select
  always_comb begin
    unique case (cfg_rate_q)
      bmrh_pkg::RATE_1200: div_reload = bmrh_pkg::DIV_1200;
      bmrh_pkg::RATE_2400: div_reload = bmrh_pkg::DIV_2400;
      bmrh_pkg::RATE_4800: div_reload = bmrh_pkg::DIV_4800;
      bmrh_pkg::RATE_9600: div_reload = bmrh_pkg::DIV_9600;
      bmrh_pkg::RATE_19200: div_reload = bmrh_pkg::DIV_19200;
      default: div_reload = bmrh_pkg::DIV_9600; // unused switch codes
    endcase
  end

  wire tick16 = cfg_done_q & (div_q == '0);

  // divider
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_q <= '0;
    end else if (!cfg_done_q || div_q == '0) begin
      div_q <= div_reload;
    end else begin
      div_q <= div_q - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // serial links and buffer
  logic [7:0] h_rx_data, m_rx_data, f_data;
  logic h_rx_valid, h_rx_perr, m_rx_valid, m_rx_perr, m_rx_busy;
  logic h_tx_busy, m_tx_ready, m_tx_busy, f_valid, f_in_ready;
  logic host_txd, modem_txd;
  logic drv_q;
  bmrh_pkg::bmrh_mstate_e st_q;

  // half duplex blinds the host receiver while the driver is on
  wire rcv_dis = cfg_half_q & drv_q;
  wire host_rxd_eff = rcv_dis | host_rxd_s;
  wire f_out_ready = (st_q == bmrh_pkg::BMRH_SEND) & m_tx_ready;

  bmrh_ser u_host (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .tick_i(tick16),
    .seven_i(seven_eff),
    .par_en_i(cfg_par_en_q),
    .par_odd_i(cfg_par_odd_q),
    .rxd_i(host_rxd_eff),
    .rx_data_o(h_rx_data),
    .rx_valid_o(h_rx_valid),
    .rx_perr_o(h_rx_perr),
    .rx_busy_o(),
    .tx_data_i(m_rx_data),
    .tx_valid_i(m_rx_valid),
    .tx_ready_o(),
    .tx_busy_o(h_tx_busy),
    .txd_o(host_txd)
  );

  bmrh_ser u_modem (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .tick_i(tick16),
    .seven_i(seven_eff),
    .par_en_i(cfg_par_en_q),
    .par_odd_i(cfg_par_odd_q),
    .rxd_i(modem_rxd_s),
    .rx_data_o(m_rx_data),
    .rx_valid_o(m_rx_valid),
    .rx_perr_o(m_rx_perr),
    .rx_busy_o(m_rx_busy),
    .tx_data_i(f_data),
    .tx_valid_i(f_out_ready & f_valid),
    .tx_ready_o(m_tx_ready),
    .tx_busy_o(m_tx_busy),
    .txd_o(modem_txd)
  );

  // host characters queue here during the hold-off
  bmrh_fifo #(
    .W(bmrh_pkg::DATA_W),
    .DEPTH(bmrh_pkg::FIFO_DEPTH)
  ) u_buf (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .in_data_i(h_rx_data),
    .in_valid_i(h_rx_valid),
    .in_ready_o(f_in_ready),
    .out_data_o(f_data),
    .out_valid_o(f_valid),
    .out_ready_i(f_out_ready)
  );

  ////////////////////////////////////////////////////////////////////////
  // modem side sequencer
  logic [15:0] ms_cyc_q;
  logic [5:0] ms_cnt_q;
  logic [9:0] hang_q;
  logic rts_q;
  logic [5:0] wait_ms;

  // wait length select
  always_comb begin
    unique case (cfg_wait_q)
      bmrh_pkg::WAIT_5MS: wait_ms = bmrh_pkg::WAIT_5_MS;
      bmrh_pkg::WAIT_10MS: wait_ms = bmrh_pkg::WAIT_10_MS;
      bmrh_pkg::WAIT_50MS: wait_ms = bmrh_pkg::WAIT_50_MS;
      bmrh_pkg::WAIT_CTS: wait_ms = '0;
    endcase
  end

  wire [3:0] n_frame = 4'h8 + {3'h0, seven_eff ? 1'b0 : 1'b1} - 4'h1 +
                       {3'h0, cfg_par_en_q} + bmrh_pkg::FRAME_EXTRA;
  wire [9:0] hang_ticks = 10'(bmrh_pkg::HANG_CHARS) * 10'(bmrh_pkg::OVS) *
                          {6'h0, n_frame};
  wire ms_tick = ms_cyc_q == 16'(MS_CYCLES - 1);
  wire wait_over = (cfg_wait_q == bmrh_pkg::WAIT_CTS) ? modem_cts_s :
                   (ms_cnt_q == wait_ms);
  wire sent_all = !f_valid & !m_tx_busy;

  // idle, wait, send, hang-over
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q <= bmrh_pkg::BMRH_IDLE;
      rts_q <= 1'b0;
      ms_cyc_q <= '0;
      ms_cnt_q <= '0;
      hang_q <= '0;
    end else begin
      unique case (st_q)
        bmrh_pkg::BMRH_IDLE: begin
          ms_cyc_q <= '0;
          ms_cnt_q <= '0;
          if (f_valid) begin
            st_q <= bmrh_pkg::BMRH_WAIT;
            rts_q <= 1'b1;
          end
        end
        bmrh_pkg::BMRH_WAIT: begin
          ms_cyc_q <= ms_tick ? '0 : ms_cyc_q + 16'h1;
          if (ms_tick) begin
            ms_cnt_q <= ms_cnt_q + 6'h1;
          end
          if (wait_over) begin
            st_q <= bmrh_pkg::BMRH_SEND;
          end
        end
        bmrh_pkg::BMRH_SEND: begin
          hang_q <= '0;
          if (sent_all) begin
            st_q <= bmrh_pkg::BMRH_HOLD;
          end
        end
        bmrh_pkg::BMRH_HOLD: begin
          if (f_valid) begin
            st_q <= bmrh_pkg::BMRH_SEND;
          end else if (tick16) begin
            hang_q <= hang_q + 10'h1;
            if (hang_q == hang_ticks - 10'h1) begin
              st_q <= bmrh_pkg::BMRH_IDLE;
              rts_q <= 1'b0;
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // host-side differential driver control
  localparam logic [9:0] DRV_TICKS = 10'(bmrh_pkg::DRV_HOLD_BITS * bmrh_pkg::OVS);
  logic [9:0] drv_cnt_q;
  logic perr_q;

  // on at first modem data, off after ten idle bit periods
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      drv_q <= 1'b0;
      drv_cnt_q <= '0;
    end else if (cfg_done_q && !modem_rxd_s) begin
      drv_q <= 1'b1;
      drv_cnt_q <= '0;
    end else if (h_tx_busy || m_rx_busy || m_rx_valid) begin
      drv_cnt_q <= '0;
    end else if (drv_q && tick16) begin
      drv_cnt_q <= drv_cnt_q + 10'h1;
      if (drv_cnt_q == DRV_TICKS - 10'h1) begin
        drv_q <= 1'b0;
      end
    end
  end

  // parity error pulse from either link
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      perr_q <= 1'b0;
    end else begin
      perr_q <= h_rx_perr | m_rx_perr;
    end
  end

  assign host_txd_o = host_txd;
  assign host_cts_o = f_in_ready;
  assign host_drv_en_o = drv_q;
  assign host_rcv_dis_o = rcv_dis;
  assign modem_txd_o = modem_txd;
  assign modem_rts_o = rts_q;
  assign parity_err_o = perr_q;
endmodule

/* File: dv/bmrh_props.sv */
/*
  Port checks on the relay top: modem line timing, rts release, driver.
  Assumes straps stable, bench rate 19200 with parity (11-bit frames).
*/
`timescale 1ns/1ps
module bmrh_props #(
  parameter int MS_CYCLES = 40,
  parameter int BIT_CYC = 2080,
  parameter int FRAME_BITS = 11
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] config_switch_bank_i,
  input wire logic duplex_select_jumper_i,
  input wire logic host_rxd_i,
  input wire logic host_txd_o,
  input wire logic host_cts_o,
  input wire logic host_drv_en_o,
  input wire logic host_rcv_dis_o,
  input wire logic modem_txd_o,
  input wire logic modem_rxd_i,
  input wire logic modem_rts_o,
  input wire logic modem_cts_i,
  input wire logic parity_err_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  int rts_age_q;
  int midle_q;
  int hidle_q;
  int min_wait;
  logic [1:0] wsel;
  ////////////////////////////////////////////////////////////////////////
  // wait selection and idle counters
  assign wsel = config_switch_bank_i[bmrh_pkg::SW_WAIT_LSB +: 2];
  assign min_wait = (wsel == 2'h1) ? 5 * MS_CYCLES - 2 : (wsel == 2'h2) ?
    10 * MS_CYCLES - 2 : (wsel == 2'h3) ? 50 * MS_CYCLES - 2 : 0;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rts_age_q <= 0;
      midle_q <= 0;
      hidle_q <= 0;
    end else begin
      rts_age_q <= modem_rts_o ? rts_age_q + 1 : 0;
      midle_q <= (modem_txd_o && modem_rts_o) ? midle_q + 1 : 0;
      hidle_q <= (host_txd_o && modem_rxd_i) ? hidle_q + 1 : 0;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // assertions
  sequence low_run_s(s);
    !s [*8];
  endsequence
  txd_quiet_a: assert property (!modem_rts_o |-> modem_txd_o)
    else $error("modem line active while rts low");
  wait_time_a: assert property ($fell(modem_txd_o) |-> rts_age_q >= min_wait)
    else $error("modem send began before the wait ended");
  rts_hang_a: assert property ($fell(modem_rts_o) |-> midle_q inside
    {[2 * FRAME_BITS * BIT_CYC : (2 * FRAME_BITS + 3) * BIT_CYC]})
    else $error("rts dropped at the wrong time");
  drv_wake_a: assert property ($fell(modem_rxd_i) |-> ##[0:4] host_drv_en_o)
    else $error("driver not on after modem data");
  drv_hold_a: assert property ($fell(host_drv_en_o) |-> hidle_q inside
    {[10 * BIT_CYC : 12 * BIT_CYC]})
    else $error("driver hold time wrong");
  drv_cover_a: assert property (!host_txd_o |-> host_drv_en_o)
    else $error("host line driven with driver off");
  rcv_gate_a: assert property (host_rcv_dis_o ==
    (duplex_select_jumper_i && host_drv_en_o))
    else $error("receiver disable mismatch");
  start_bit_a: assert property ($fell(modem_txd_o) |-> low_run_s(modem_txd_o))
    else $error("modem start bit too short");
  host_start_a: assert property ($fell(host_txd_o) |-> low_run_s(host_txd_o))
    else $error("host start bit too short");
  cts_room_a: assert property (!modem_rts_o |-> host_cts_o)
    else $error("host cts low with empty buffer");
endmodule
bind bmrh_top bmrh_props #(.MS_CYCLES(MS_CYCLES)) u_props (.clk_i(clk_i), .nrst_i(nrst_i),
  .config_switch_bank_i(config_switch_bank_i),
  .duplex_select_jumper_i(duplex_select_jumper_i), .host_rxd_i(host_rxd_i),
  .host_txd_o(host_txd_o), .host_cts_o(host_cts_o), .host_drv_en_o(host_drv_en_o),
  .host_rcv_dis_o(host_rcv_dis_o), .modem_txd_o(modem_txd_o), .modem_rxd_i(modem_rxd_i),
  .modem_rts_o(modem_rts_o), .modem_cts_i(modem_cts_i), .parity_err_o(parity_err_o));

/* File: dv/bmrh_modem.sv */
/*
  Behavioural radio modem: captures frames from the relay, sends frames
  back, answers rts with cts after a set lag. Assumes 8 data, even parity.
*/
`timescale 1ns/1ps
module bmrh_modem #(
  parameter int BIT_CYC = 2080,
  parameter int CTS_LAG = 0
) (
  input wire logic clk_i,
  input wire logic txd_i,
  input wire logic rts_i,
  output logic rxd_o,
  output logic cts_o
);
  logic [10:0] frame_q;
  int got = 0;
  int lag = 0;
  initial rxd_o = 1'b1;
  initial cts_o = 1'b0;
  // cts answers rts, promptly or slowly
  always @(posedge clk_i) begin
    lag <= rts_i ? lag + 1 : 0;
    cts_o <= rts_i && (lag >= CTS_LAG);
  end
  // capture one frame per start edge, sampled mid-bit
  always begin
    @(negedge txd_i);
    repeat (BIT_CYC / 2) @(posedge clk_i);
    for (int i = 0; i < 11; i++) begin
      frame_q[i] = txd_i;
      repeat (i < 10 ? BIT_CYC : 0) @(posedge clk_i);
    end
    got++;
  end
  // send start, data lsb first, even parity, stop; line then idles high
  task automatic send(input logic [7:0] d);
    logic [10:0] f;
    f = {1'b1, ^d, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxd_o = f[i];
      repeat (BIT_CYC) @(posedge clk_i);
      #2;
    end
  endtask
endmodule

/* File: dv/testbench.sv */
/*
  Self-checking bench for the relay top: one host char out to the modem,
  one modem char back to the host, then a reset into full duplex.
  Assumes the modem model beside it.
*/
`timescale 1ns/1ps
module testbench;
  localparam int MS = 40;
  localparam int BIT = 16 * (int'(bmrh_pkg::DIV_19200) + 1);
  localparam int FRAME = 11;
  localparam logic [7:0] CFG = 8'h54; // 19200, 8 data, even parity, 5 ms
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [7:0] cfg = CFG;
  logic jmp = 1'b1;
  logic host_rxd = 1'b1;
  logic host_txd_o, host_cts_o, host_drv_en_o, host_rcv_dis_o;
  logic modem_txd_o, modem_rxd, modem_rts_o, modem_cts, parity_err_o;
  int miscompares = 0;
  int checked = 0;
  int perr_seen = 0;
  ////////////////////////////////////////////////////////////////////////
  // design and modem
  bmrh_top #(.MS_CYCLES(MS)) u_dut (.clk_i(clk_i), .nrst_i(nrst_i),
    .config_switch_bank_i(cfg), .duplex_select_jumper_i(jmp), .host_rxd_i(host_rxd),
    .host_txd_o(host_txd_o), .host_cts_o(host_cts_o), .host_drv_en_o(host_drv_en_o),
    .host_rcv_dis_o(host_rcv_dis_o), .modem_txd_o(modem_txd_o), .modem_rxd_i(modem_rxd),
    .modem_rts_o(modem_rts_o), .modem_cts_i(modem_cts), .parity_err_o(parity_err_o));
  bmrh_modem #(.BIT_CYC(BIT), .CTS_LAG(30)) u_modem (.clk_i(clk_i), .txd_i(modem_txd_o),
    .rts_i(modem_rts_o), .rxd_o(modem_rxd), .cts_o(modem_cts));
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////////
  // helpers
  // parity error pulses seen, clean traffic must give none
  always @(posedge clk_i) begin
    if (parity_err_o === 1'h1) begin
      perr_seen++;
    end
  end
  task automatic tick();
    @(posedge clk_i);
    #2;
  endtask
  task automatic chk_bit(input string n, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      $display("[ERR] %s expected %b seen %b", n, e, g);
      miscompares++;
    end
  endtask
  task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      miscompares++;
    end
  endtask
  task automatic end_sim();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic tmo(input int n, input int lim);
    if (n >= lim) begin
      $display("[ERR] wait expected under %0d cycles seen %0d", lim, n);
      miscompares++;
      end_sim();
    end
  endtask
  task automatic host_send(input logic [7:0] d);
    logic [10:0] f;
    f = {1'b1, ^d, d, 1'b0};
    chk_bit("host_cts", 1'b1, host_cts_o);
    for (int i = 0; i < 11; i++) begin
      host_rxd = f[i];
      repeat (BIT) tick();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic sc_idle();
    repeat (200) tick();
    chk_bit("rts_idle", 1'b0, modem_rts_o);
    chk_bit("cts_empty", 1'b1, host_cts_o);
    chk_bit("drv_idle", 1'b0, host_drv_en_o);
    chk_bit("rcv_dis_idle", 1'b0, host_rcv_dis_o);
  endtask
  task automatic sc_host_to_modem();
    int n;
    cfg = {CFG[7:4], 4'h8};
    fork
      host_send(8'ha5);
      begin
        for (n = 0; n < 2 * FRAME * BIT && !modem_rts_o; n++) tick();
        tmo(n, 2 * FRAME * BIT);
        chk_bit("rts_up", 1'b1, modem_rts_o);
        for (n = 0; n < 60 * MS && modem_txd_o; n++) tick();
        tmo(n, 60 * MS);
        chk_bit("wait_5ms", 1'b1, n >= 5 * MS - 2 && n <= 5 * MS + 16);
      end
    join
  endtask
  task automatic sc_modem_rx();
    int n;
    for (n = 0; n < 2 * FRAME * BIT && u_modem.got == 0; n++) tick();
    tmo(n, 2 * FRAME * BIT);
    chk_bit("modem_start", 1'b0, u_modem.frame_q[0]);
    chk_byte("modem_data", 8'ha5, u_modem.frame_q[8:1]);
    chk_bit("modem_par", ^8'ha5, u_modem.frame_q[9]);
    chk_bit("modem_stop", 1'b1, u_modem.frame_q[10]);
    for (n = 0; n < 3 * FRAME * BIT && modem_rts_o; n++) tick();
    tmo(n, 3 * FRAME * BIT);
    chk_bit("rts_hang", 1'b1, n >= 2 * FRAME * BIT && n <= (2 * FRAME + 2) * BIT);
  endtask
  task automatic sc_host_rx();
    logic [10:0] f;
    int n;
    for (n = 0; n < 3 * FRAME * BIT && host_txd_o; n++) tick();
    tmo(n, 3 * FRAME * BIT);
    repeat (BIT / 2) tick();
    chk_bit("drv_on", 1'b1, host_drv_en_o);
    chk_bit("rcv_dis_half", 1'b1, host_rcv_dis_o);
    for (int i = 0; i < 11; i++) begin
      f[i] = host_txd_o;
      repeat (i < 10 ? BIT : 0) tick();
    end
    chk_bit("host_start", 1'b0, f[0]);
    chk_byte("host_data", 8'h3c, f[8:1]);
    chk_bit("host_par", ^8'h3c, f[9]);
    chk_bit("host_stop", 1'b1, f[10]);
    for (n = 0; n < 13 * BIT && host_drv_en_o; n++) tick();
    tmo(n, 13 * BIT);
    chk_bit("drv_hold", 1'b1, n >= 10 * BIT && n <= 12 * BIT);
    chk_bit("parity_quiet", 1'h0, perr_seen != 0);
  endtask
  task automatic sc_full_duplex();
    nrst_i = 1'h0;
    jmp = 1'h0;
    repeat (4) tick();
    nrst_i = 1'h1;
    repeat (8) tick();
    chk_bit("drv_reset", 1'h0, host_drv_en_o);
    fork
      u_modem.send(8'h5a);
    join_none
    repeat (8) tick();
    chk_bit("drv_on_full", 1'h1, host_drv_en_o);
    chk_bit("rcv_en_full", 1'h0, host_rcv_dis_o);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (4) tick();
    nrst_i = 1'b1;
    sc_idle();
    sc_host_to_modem();
    fork
      u_modem.send(8'h3c);
      sc_modem_rx();
      sc_host_rx();
    join
    sc_full_duplex();
    end_sim();
  end
endmodule
